// [src/cmd_err_pkg.sv]
// Constants and carrier types for the command parser error checker and its queue.
// Assumes one clock domain; the parser front end delivers classified characters.
// Function
// - An error query on an empty queue returns code +0, no error.
// - Power-on reset or the clear-status command empties the error queue.
// - Generic syntax fault with nothing more specific logs -100.
// - Character invalid for the element being parsed logs -101.
// - Unrecognised command or data type logs -102.
// - Illegal character where a separator is expected logs -103.
// - Block data where the header takes none logs -104.
// - Too many parameters log -108; too few log -109.
// - Header or character data over twelve characters logs -112.
// - Well-formed header matching no command logs -113.
// - Numeric fault with nothing more specific logs -120.
// - Character invalid for the numeric radix logs -121.
// - Decimal mantissa over 255 significant digits logs -124.
// - Legal number where the header takes none logs -128.
// - Malformed or inappropriate suffix logs -131.
// - Suffix over 12 characters logs -134.
// - Suffix after a number that allows none logs -138.
package cmd_err_pkg;

  // Signed error codes
  localparam logic signed [15:0] CODE_NONE        = 16'sh0000;
  localparam logic signed [15:0] CODE_CMD         = -16'sh0064; // -100
  localparam logic signed [15:0] CODE_BAD_CHAR    = -16'sh0065; // -101
  localparam logic signed [15:0] CODE_SYNTAX      = -16'sh0066; // -102
  localparam logic signed [15:0] CODE_BAD_SEP     = -16'sh0067; // -103
  localparam logic signed [15:0] CODE_DATA_TYPE   = -16'sh0068; // -104
  localparam logic signed [15:0] CODE_PARM_EXTRA  = -16'sh006C; // -108
  localparam logic signed [15:0] CODE_PARM_MISS   = -16'sh006D; // -109
  localparam logic signed [15:0] CODE_HDR_LONG    = -16'sh0070; // -112
  localparam logic signed [15:0] CODE_HDR_UNDEF   = -16'sh0071; // -113
  localparam logic signed [15:0] CODE_NUM         = -16'sh0078; // -120
  localparam logic signed [15:0] CODE_NUM_CHAR    = -16'sh0079; // -121
  localparam logic signed [15:0] CODE_NUM_DIGITS  = -16'sh007C; // -124
  localparam logic signed [15:0] CODE_NUM_BANNED  = -16'sh0080; // -128
  localparam logic signed [15:0] CODE_SFX_BAD     = -16'sh0083; // -131
  localparam logic signed [15:0] CODE_SFX_LONG    = -16'sh0086; // -134
  localparam logic signed [15:0] CODE_SFX_BANNED  = -16'sh008A; // -138

  // Limits
  localparam logic [3:0] NAME_MAX      = 4'hC; // Header, character data, suffix
  localparam logic [8:0] DIGIT_MAX     = 9'h0FF; // Significant mantissa digits
  localparam int         QUEUE_DEPTH   = 8;
  localparam int         QUEUE_AW      = 3;

  // Parser element kinds
  typedef enum logic [2:0] {
    EL_IDLE   = 3'b000,
    EL_HEADER = 3'b001,
    EL_SEP    = 3'b010,
    EL_NUMBER = 3'b011,
    EL_SUFFIX = 3'b100,
    EL_CHARS  = 3'b101,
    EL_STRING = 3'b110,
    EL_BLOCK  = 3'b111
  } elem_t;

  // Numeric radix in use
  typedef enum logic [1:0] {
    RADIX_DEC = 2'b00,
    RADIX_HEX = 2'b01,
    RADIX_OCT = 2'b10,
    RADIX_BIN = 2'b11
  } radix_t;

  // One classified character from the front end
  typedef struct packed {
    logic       valid;
    logic [7:0] ch;
    elem_t      kind;      // Element this character belongs to
    logic       first;     // First character of the element
    logic       last;      // Element ends after this character
    logic       end_msg;   // Program message terminator seen
  } char_in_t;

  // Properties of the header just matched, from the command table
  typedef struct packed {
    logic       known;       // Header matches a defined command
    logic       allow_num;   // Header accepts a numeric value
    logic       allow_sfx;   // Numeric value may carry a suffix
    logic       allow_block; // Header accepts block data
    logic       sfx_ok;      // Suffix text is one the device knows
    logic [3:0] min_parms;
    logic [3:0] max_parms;
    radix_t     radix;
  } hdr_info_t;

  // Query answer
  typedef struct packed {
    logic              valid;
    logic signed [15:0] code;
  } err_ans_t;

endpackage

// [src/err_queue.sv]
// First-in first-out store of signed error codes.
// Assumes push and pop come from one clock domain; clear wins over both.
`timescale 1ns/10ps
`default_nettype none
module err_queue
  import cmd_err_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Control
  input  wire logic               clear,
  input  wire logic               push,
  input  wire logic signed [15:0] push_code,
  input  wire logic               pop,
  // Answer
  output logic signed [15:0]      head_code,
  output logic                    empty,
  output logic                    full
);

  logic signed [15:0]  mem_ff [QUEUE_DEPTH];
  logic [QUEUE_AW-1:0] rd_ff;
  logic [QUEUE_AW-1:0] nxt_rd;
  logic [QUEUE_AW-1:0] wr_ff;
  logic [QUEUE_AW-1:0] nxt_wr;
  logic [QUEUE_AW:0]   cnt_ff;
  logic [QUEUE_AW:0]   nxt_cnt;
  logic                do_push;
  logic                do_pop;

  // Empty queue reads as no error
  assign empty     = (cnt_ff == '0);
  assign full      = (cnt_ff == (QUEUE_AW+1)'(QUEUE_DEPTH));
  assign head_code = empty ? CODE_NONE : mem_ff[rd_ff];
  assign do_pop    = pop && !empty;
  assign do_push   = push && (!full || do_pop);

  // Pointer and count next values
  always_comb begin
    nxt_rd  = rd_ff;
    nxt_wr  = wr_ff;
    nxt_cnt = cnt_ff;
    if (clear) begin
      nxt_rd  = '0;
      nxt_wr  = '0;
      nxt_cnt = '0;
    end else begin
      if (do_pop) begin
        nxt_rd = rd_ff + 1'b1;
      end
      if (do_push) begin
        nxt_wr = wr_ff + 1'b1;
      end
      nxt_cnt = cnt_ff + {{QUEUE_AW{1'b0}}, do_push} - {{QUEUE_AW{1'b0}}, do_pop};
    end
  end

  // Register pointers and storage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_ff  <= '0;
      wr_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      rd_ff  <= nxt_rd;
      wr_ff  <= nxt_wr;
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge clk) begin
    if (do_push && !clear) begin
      mem_ff[wr_ff] <= push_code;
    end
  end

  a_pop_order : assert property (@(posedge clk) disable iff (!rst_n)
    (cnt_ff == 0 && push && !pop && !clear) |=> (head_code == $past(push_code)))
    else $error("Oldest code not at head");

endmodule
`default_nettype wire

// [src/cmd_err_check.sv]
// Command parser error detector feeding an ordered error queue.
// Assumes a front end that tokenises serial text into classified characters
// and a command table that looks up each completed header.
`timescale 1ns/10ps
`default_nettype none
module cmd_err_check
  import cmd_err_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // Character stream from the front end
  input  wire cmd_err_pkg::char_in_t cin,
  // Lookup result for the current header, sampled with its last character
  input  wire cmd_err_pkg::hdr_info_t hdr,
  // Lexical faults flagged by the front end
  input  wire logic                 bad_sep,
  input  wire logic                 bad_element,
  input  wire logic                 unknown_type,
  input  wire logic                 num_malformed,
  input  wire logic                 sfx_malformed,
  input  wire logic                 syntax_other,
  // Common commands and queries
  input  wire logic                 clear_status,
  input  wire logic                 err_query,
  // Query answer
  output cmd_err_pkg::err_ans_t     ans,
  output logic                      queue_full
);

  // Parser tracking state
  typedef enum logic [1:0] {
    PS_HEADER = 2'b00,
    PS_PARAMS = 2'b01,
    PS_SKIP   = 2'b10
  } pstate_t;

  pstate_t          ps_ff;
  pstate_t          nxt_ps;
  logic [3:0]       len_ff;
  logic [3:0]       nxt_len;
  logic             long_ff;
  logic             nxt_long;
  logic [8:0]       dig_ff;
  logic [8:0]       nxt_dig;
  logic             sig_ff;
  logic             nxt_sig;
  logic [3:0]       parms_ff;
  logic [3:0]       nxt_parms;
  hdr_info_t        hinfo_ff;
  hdr_info_t        nxt_hinfo;
  err_ans_t         ans_ff;
  err_ans_t         nxt_ans;
  logic             log_en;
  logic signed [15:0] log_code;
  logic             q_empty;
  logic signed [15:0] q_head;

  // Is this character a legal digit for the radix
  function automatic logic digit_ok(input logic [7:0] c, input radix_t r);
    logic d;
    d = 1'b0;
    unique case (r)
      RADIX_DEC: d = (c >= 8'h30 && c <= 8'h39) || c == 8'h2E || c == 8'h2B || c == 8'h2D
                     || c == 8'h45 || c == 8'h65;
      RADIX_HEX: d = (c >= 8'h30 && c <= 8'h39) || (c >= 8'h41 && c <= 8'h46)
                     || (c >= 8'h61 && c <= 8'h66);
      RADIX_OCT: d = (c >= 8'h30 && c <= 8'h37);
      RADIX_BIN: d = (c == 8'h30 || c == 8'h31);
    endcase
    return d;
  endfunction

  // Is the character a letter, digit, underscore or one of : * ? / . of a name
  function automatic logic name_ok(input logic [7:0] c);
    return (c >= 8'h41 && c <= 8'h5A) || (c >= 8'h61 && c <= 8'h7A)
           || (c >= 8'h30 && c <= 8'h39) || c == 8'h5F || c == 8'h3A
           || c == 8'h2A || c == 8'h3F || c == 8'h2F || c == 8'h2E;
  endfunction

  wire logic in_name = cin.kind == EL_HEADER || cin.kind == EL_CHARS
                       || cin.kind == EL_SUFFIX;
  wire logic is_digit = cin.ch >= 8'h30 && cin.ch <= 8'h39;
  wire logic hdr_end  = cin.valid && cin.kind == EL_HEADER && cin.last;

  // Detect one fault per character, most specific first, and track counts
  always_comb begin
    nxt_ps    = ps_ff;
    nxt_len   = len_ff;
    nxt_long  = long_ff;
    nxt_dig   = dig_ff;
    nxt_sig   = sig_ff;
    nxt_parms = parms_ff;
    nxt_hinfo = hinfo_ff;
    log_en    = 1'b0;
    log_code  = CODE_CMD;
    if (cin.valid) begin
      // Name length counting for header, character data and suffix
      if (in_name) begin
        if (cin.first) begin
          nxt_len  = 4'h1;
          nxt_long = 1'b0;
        end else if (len_ff == NAME_MAX) begin
          nxt_long = 1'b1;
        end else begin
          nxt_len = len_ff + 4'h1;
        end
      end
      // Significant mantissa digit counting, leading zeros excluded
      if (cin.kind == EL_NUMBER) begin
        if (cin.first) begin
          nxt_dig = '0;
          nxt_sig = 1'b0;
        end
        // A zero counts only once a nonzero digit of this same number was seen
        if (is_digit && (cin.ch != 8'h30 || (!cin.first && sig_ff))) begin
          nxt_sig = 1'b1;
          if (cin.first || dig_ff != 9'h1FF) begin
            nxt_dig = (cin.first ? 9'h000 : dig_ff) + 9'h001;
          end
        end
      end
      if (cin.kind == EL_HEADER && cin.first) begin
        nxt_parms = '0;
      end
      // Count parameters as they start, so the missing check sees this one
      if (cin.kind != EL_HEADER && cin.kind != EL_SEP && cin.kind != EL_IDLE
          && cin.kind != EL_SUFFIX && cin.first && parms_ff != 4'hF) begin
        nxt_parms = parms_ff + 4'h1;
      end
      if (ps_ff != PS_SKIP) begin
        if (bad_sep) begin
          log_en = 1'b1; log_code = CODE_BAD_SEP;
        end else if (unknown_type) begin
          log_en = 1'b1; log_code = CODE_SYNTAX;
        end else if (cin.kind == EL_BLOCK && cin.first && !hinfo_ff.allow_block) begin
          log_en = 1'b1; log_code = CODE_DATA_TYPE;
        end else if (cin.kind == EL_NUMBER && !digit_ok(cin.ch, hinfo_ff.radix)) begin
          log_en = 1'b1; log_code = CODE_NUM_CHAR;
        end else if (cin.kind == EL_NUMBER && cin.last && hinfo_ff.radix == RADIX_DEC
                     && nxt_dig > DIGIT_MAX) begin
          log_en = 1'b1; log_code = CODE_NUM_DIGITS;
        end else if (cin.kind == EL_NUMBER && num_malformed) begin
          log_en = 1'b1; log_code = CODE_NUM;
        end else if (cin.kind == EL_NUMBER && cin.last && !hinfo_ff.allow_num) begin
          log_en = 1'b1; log_code = CODE_NUM_BANNED;
        end else if (cin.kind == EL_SUFFIX && cin.first && !hinfo_ff.allow_sfx) begin
          log_en = 1'b1; log_code = CODE_SFX_BANNED;
        end else if (cin.kind == EL_SUFFIX && cin.last && nxt_long) begin
          log_en = 1'b1; log_code = CODE_SFX_LONG;
        end else if (cin.kind == EL_SUFFIX && cin.last && (sfx_malformed || !hinfo_ff.sfx_ok)) begin
          log_en = 1'b1; log_code = CODE_SFX_BAD;
        end else if ((in_name && !name_ok(cin.ch)) || bad_element) begin
          log_en = 1'b1; log_code = CODE_BAD_CHAR;
        end else if ((cin.kind == EL_HEADER || cin.kind == EL_CHARS) && cin.last && nxt_long) begin
          log_en = 1'b1; log_code = CODE_HDR_LONG;
        end else if (hdr_end && !hdr.known) begin
          log_en = 1'b1; log_code = CODE_HDR_UNDEF;
        end else if (cin.kind != EL_HEADER && cin.kind != EL_SEP && cin.kind != EL_IDLE
                     && cin.first && parms_ff == hinfo_ff.max_parms) begin
          log_en = 1'b1; log_code = CODE_PARM_EXTRA;
        end else if (cin.end_msg && (ps_ff == PS_PARAMS || hdr_end)
                     && nxt_parms < (hdr_end ? hdr.min_parms : hinfo_ff.min_parms)) begin
          log_en = 1'b1; log_code = CODE_PARM_MISS;
        end else if (syntax_other) begin
          log_en = 1'b1; log_code = CODE_CMD;
        end
      end
      // Header lookup captured; one fault skips checks until the message ends or a later header ends
      if (hdr_end) begin
        nxt_hinfo = hdr;
        nxt_ps    = PS_PARAMS;
      end
      if (log_en) begin
        nxt_ps = PS_SKIP;
      end
      if (cin.end_msg) begin
        nxt_ps = PS_HEADER;
      end
    end
  end

  // Register parser tracking state
  always_ff @(posedge clk) begin
    if (!rst_n || clear_status) begin
      ps_ff    <= PS_HEADER;
      len_ff   <= '0;
      long_ff  <= 1'b0;
      dig_ff   <= '0;
      sig_ff   <= 1'b0;
      parms_ff <= '0;
      hinfo_ff <= '0;
    end else begin
      ps_ff    <= nxt_ps;
      len_ff   <= nxt_len;
      long_ff  <= nxt_long;
      dig_ff   <= nxt_dig;
      sig_ff   <= nxt_sig;
      parms_ff <= nxt_parms;
      hinfo_ff <= nxt_hinfo;
    end
  end

  // Ordered error store
  err_queue u_queue (
    .clk       (clk),
    .rst_n     (rst_n),
    .clear     (clear_status),
    .push      (log_en),
    .push_code (log_code),
    .pop       (err_query),
    .head_code (q_head),
    .empty     (q_empty),
    .full      (queue_full)
  );

  // Query answer: oldest code, or +0 when nothing is stored
  always_comb begin
    nxt_ans.valid = err_query;
    nxt_ans.code  = ans_ff.code;
    if (err_query) begin
      nxt_ans.code = q_empty ? CODE_NONE : q_head;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ans_ff <= '0;
    end else begin
      ans_ff <= nxt_ans;
    end
  end

  assign ans = ans_ff;

  // Checks
  a_empty_zero : assert property (@(posedge clk) disable iff (!rst_n)
    (err_query && q_empty) |=> (ans.valid && ans.code == CODE_NONE))
    else $error("Empty query not +0");
  a_cls_clears : assert property (@(posedge clk) disable iff (!rst_n)
    clear_status |=> q_empty)
    else $error("Clear did not empty queue");
  a_octal_nine : assert property (@(posedge clk) disable iff (!rst_n)
    (cin.valid && ps_ff != PS_SKIP && !bad_sep && !unknown_type && cin.kind == EL_NUMBER
     && hinfo_ff.radix == RADIX_OCT && cin.ch == 8'h39) |-> (log_en && log_code == CODE_NUM_CHAR))
    else $error("Octal nine not -121");
  a_undef_hdr : assert property (@(posedge clk) disable iff (!rst_n)
    (log_en && log_code == CODE_HDR_UNDEF) |-> (hdr_end && !hdr.known))
    else $error("Bad -113 cause");
  a_sep_code : assert property (@(posedge clk) disable iff (!rst_n)
    (cin.valid && ps_ff != PS_SKIP && bad_sep) |-> (log_en && log_code == CODE_BAD_SEP))
    else $error("Separator fault not -103");
  a_skip_rest : assert property (@(posedge clk) disable iff (!rst_n || clear_status)
    (log_en && !cin.end_msg) |=> (ps_ff == PS_SKIP))
    else $error("Parser did not skip after fault");
  a_query_pop : assert property (@(posedge clk) disable iff (!rst_n)
    (err_query && !q_empty && !clear_status) |=> (ans.valid && ans.code == $past(q_head)))
    else $error("Query did not return the oldest code");
  a_long_sfx : assert property (@(posedge clk) disable iff (!rst_n)
    (log_en && log_code == CODE_SFX_LONG) |-> (cin.kind == EL_SUFFIX && nxt_long))
    else $error("Bad -134 cause");

  c_query_hit   : cover property (@(posedge clk) err_query && !q_empty);
  c_query_empty : cover property (@(posedge clk) err_query && q_empty);
  c_undef       : cover property (@(posedge clk) log_en && log_code == CODE_HDR_UNDEF);
  c_full        : cover property (@(posedge clk) queue_full);

endmodule
`default_nettype wire

// [dv/host_model.sv]
// Behavioural host side: classified character stream, fault flags, header lookup.
// Assumes the bench calls its tasks just after a rising edge of clk.
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // Clock
  input  wire logic                  clk,
  // Stream toward the checker
  output var cmd_err_pkg::char_in_t  cin,
  output var cmd_err_pkg::hdr_info_t hdr,
  output var logic [5:0]             flags
);
  import cmd_err_pkg::*;

  // Quiet stream at time zero
  initial begin
    cin   = '0;
    hdr   = '0;
    flags = '0;
  end

  // One character per edge, flags ride with it
  task automatic put(input elem_t k, input logic [7:0] c, input logic f, input logic l,
                     input logic e, input logic [5:0] fl);
    @(posedge clk);
    cin   <= '{1'b1, c, k, f, l, e};
    flags <= fl;
  endtask

  // Released lines show a changing pattern, not the last value
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk);
      cin   <= '{1'b0, ~cin.ch, EL_IDLE, ~cin.first, ~cin.last, 1'b0};
      flags <= ~flags;
    end
  endtask

  // Table answer for the next header
  task automatic set_hdr(input hdr_info_t h);
    hdr <= h;
  endtask
endmodule
`default_nettype wire

// [dv/tb_cmd_err_check.sv]
// Self-checking bench for the command parser error checker and its queue.
// Assumes host_model drives the stream; the bench drives query, clear and reset.
`timescale 1ns/10ps
`default_nettype none
module tb_cmd_err_check;
  import cmd_err_pkg::*;

  // Permissive header: known, all data kinds, 0..15 parameters, decimal
  localparam hdr_info_t HDR_OK = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 4'h0, 4'hF, RADIX_DEC};

  logic      clk;
  logic      rst_n;
  logic      clear_status;
  logic      err_query;
  char_in_t  cin;
  hdr_info_t hdr;
  logic [5:0] flags;
  err_ans_t  ans;
  logic      queue_full;
  int        n_fail;
  int        cmp_count;

  // Clock, 25 ns period
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  host_model host (.clk(clk), .cin(cin), .hdr(hdr), .flags(flags));

  cmd_err_check uut (
    .clk(clk), .rst_n(rst_n), .cin(cin), .hdr(hdr),
    .bad_sep(flags[0]), .bad_element(flags[1]), .unknown_type(flags[2]),
    .num_malformed(flags[3]), .sfx_malformed(flags[4]), .syntax_other(flags[5]),
    .clear_status(clear_status), .err_query(err_query),
    .ans(ans), .queue_full(queue_full)
  );

  // Code expected for each front-end fault flag
  function automatic logic [15:0] flag_code(input int i);
    case (i)
      0: return CODE_BAD_SEP;
      1: return CODE_BAD_CHAR;
      2: return CODE_SYNTAX;
      3: return CODE_NUM;
      4: return CODE_SFX_BAD;
      default: return CODE_CMD;
    endcase
  endfunction

  // Verdict and end of run
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Single compare point
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Query pulse; answer stands in the cycle after
  task automatic query(input logic [15:0] exp);
    @(posedge clk);
    err_query <= 1'b1;
    @(posedge clk);
    err_query <= 1'b0;
    #1;
    check("ans_valid", {15'h0, ans.valid}, 16'h0001);
    check("ans_code", ans.code, exp);
  endtask

  // One element of n characters, z leading zeros, flag on the last one
  task automatic elem(input elem_t k, input int n, input logic [7:0] c, input logic e,
                      input logic [5:0] fl = 6'h00, input int z = 0);
    for (int i = 0; i < n; i++) begin
      host.put(k, (i < z) ? 8'h30 : c, i == 0, i == n - 1, e && (i == n - 1),
               (i == n - 1) ? fl : 6'h00);
    end
  endtask

  // Header, space, optional number, then one closing element; query result
  task automatic one(input hdr_info_t h, input elem_t k, input int n, input logic [7:0] c,
                     input logic [15:0] exp, input logic [5:0] fl = 6'h00, input int z = 0);
    host.set_hdr(h);
    elem(EL_HEADER, 4, 8'h41, 1'b0);
    elem(EL_SEP, 1, 8'h20, 1'b0);
    if (k == EL_SUFFIX) elem(EL_NUMBER, 1, 8'h35, 1'b0);
    elem(k, n, c, 1'b1, fl, z);
    host.idle(2);
    query(exp);
  endtask

  // Header alone as a whole message
  task automatic hdr_only(input hdr_info_t h, input int len, input logic [15:0] exp);
    host.set_hdr(h);
    elem(EL_HEADER, len, 8'h48, 1'b1);
    host.idle(2);
    query(exp);
  endtask

  // Watchdog, far beyond the expected run of under two thousand cycles
  initial begin
    #1_000_000;
    n_fail++;
    stop_test();
  end

  // Main sequence
  initial begin
    hdr_info_t   h;
    int          n;
    int          j;
    logic [15:0] exq[$];
    rst_n        = 1'b0;
    clear_status = 1'b0;
    err_query    = 1'b0;
    n_fail       = 0;
    cmp_count    = 0;
    void'($urandom(32'he3e8));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    query(CODE_NONE);
    h = HDR_OK;
    h.known = 1'b0;
    hdr_only(h, 5, CODE_HDR_UNDEF);
    hdr_only(HDR_OK, 13, CODE_HDR_LONG);
    hdr_only(HDR_OK, 12, CODE_NONE);
    // Every front-end fault flag
    for (int i = 0; i < 6; i++) begin
      one(HDR_OK, (i == 4) ? EL_SUFFIX : EL_NUMBER, 1, (i == 4) ? 8'h56 : 8'h35,
          flag_code(i), 6'h01 << i);
    end
    h = HDR_OK;
    h.radix = RADIX_OCT;
    one(h, EL_NUMBER, 1, 8'h39, CODE_NUM_CHAR);
    h.radix = RADIX_BIN;
    one(h, EL_NUMBER, 1, 8'h32, CODE_NUM_CHAR);
    one(HDR_OK, EL_NUMBER, 256, 8'h31, CODE_NUM_DIGITS);
    one(HDR_OK, EL_NUMBER, 258, 8'h31, CODE_NONE, 6'h00, 3);
    h = HDR_OK;
    h.allow_num = 1'b0;
    one(h, EL_NUMBER, 1, 8'h35, CODE_NUM_BANNED);
    h = HDR_OK;
    h.allow_block = 1'b0;
    one(h, EL_BLOCK, 3, 8'h23, CODE_DATA_TYPE);
    h = HDR_OK;
    h.allow_sfx = 1'b0;
    one(h, EL_SUFFIX, 2, 8'h56, CODE_SFX_BANNED);
    one(HDR_OK, EL_SUFFIX, 13, 8'h56, CODE_SFX_LONG);
    one(HDR_OK, EL_SUFFIX, 12, 8'h56, CODE_NONE);
    h = HDR_OK;
    h.sfx_ok = 1'b0;
    one(h, EL_SUFFIX, 2, 8'h56, CODE_SFX_BAD);
    h = HDR_OK;
    h.min_parms = 4'h2;
    one(h, EL_NUMBER, 1, 8'h35, CODE_PARM_MISS);
    hdr_only(h, 4, CODE_PARM_MISS);
    // Two parameters where one is the most
    h = HDR_OK;
    h.max_parms = 4'h1;
    host.set_hdr(h);
    elem(EL_HEADER, 4, 8'h41, 1'b0);
    elem(EL_SEP, 1, 8'h20, 1'b0);
    elem(EL_NUMBER, 1, 8'h31, 1'b0);
    elem(EL_SEP, 1, 8'h2C, 1'b0);
    elem(EL_NUMBER, 1, 8'h32, 1'b1);
    host.idle(2);
    query(CODE_PARM_EXTRA);
    // Random bursts of faults, up to one past the queue depth
    repeat (5) begin
      n = 1 + $urandom % 9;
      for (int i = 0; i < n; i++) begin
        j = $urandom % 5;
        if (j == 4) j = 5;
        if (exq.size() < 8) exq.push_back(flag_code(j));
        host.set_hdr(HDR_OK);
        elem(EL_HEADER, 1 + $urandom % 12, 8'(8'h41 + $urandom % 26), 1'b0);
        elem(EL_NUMBER, 1, 8'h35, 1'b1, 6'h01 << j);
      end
      host.idle(2);
      check("queue_full", {15'h0, queue_full}, {15'h0, n >= 8});
      for (int i = 0; i <= n; i++) begin
        query((exq.size() > 0) ? exq.pop_front() : CODE_NONE);
      end
    end
    // Clear-status empties a loaded queue
    one(HDR_OK, EL_NUMBER, 1, 8'h35, CODE_NUM, 6'h08);
    elem(EL_HEADER, 13, 8'h41, 1'b1);
    elem(EL_HEADER, 13, 8'h41, 1'b1);
    @(posedge clk);
    clear_status <= 1'b1;
    @(posedge clk);
    clear_status <= 1'b0;
    query(CODE_NONE);
    // Reset in mid-run empties it too
    elem(EL_HEADER, 13, 8'h41, 1'b1);
    host.idle(2);
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    query(CODE_NONE);
    stop_test();
  end
endmodule
`default_nettype wire
